// [core/hgp_pkg.sv]
// Shared constants, modes and state layout for the pad I/O logic
package hgp_pkg;

  localparam int unsigned SER_W = 4;
  localparam int unsigned DYN_TAPS = 64;
  localparam int unsigned DYN_STEP_PS = 25;
  localparam int unsigned STAT_SE_STEP_PS = 60;
  localparam logic [5:0] STAT_SE_MAX = 6'h0f;
  localparam logic [5:0] DYN_TAP_MAX = 6'h3f;
  localparam logic [5:0] DYN_TAP_INIT = 6'h00;
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  // One slow clock period is four fast cycles; phases are one-hot
  typedef enum logic [3:0] {
    HGP_PH_RISE = 4'h1,
    HGP_PH_Q1 = 4'h2,
    HGP_PH_FALL = 4'h4,
    HGP_PH_Q3 = 4'h8
  } hgp_phase_e;

  typedef enum logic [1:0] {
    HGP_DIR_UNUSED = 2'h0,
    HGP_DIR_INPUT = 2'h1,
    HGP_DIR_OUTPUT = 2'h2,
    HGP_DIR_INOUT = 2'h3
  } hgp_dir_e;

  typedef enum logic [1:0] {
    HGP_IN_DIRECT = 2'h0,
    HGP_IN_REG = 2'h1,
    HGP_IN_DDR = 2'h2,
    HGP_IN_DESER = 2'h3
  } hgp_in_mode_e;

  typedef enum logic [1:0] {
    HGP_AL_NORMAL = 2'h0,
    HGP_AL_RESYNC = 2'h1,
    HGP_AL_PIPELINE = 2'h2
  } hgp_align_e;

  typedef enum logic [2:0] {
    HGP_OUT_DIRECT = 3'h0,
    HGP_OUT_REG = 3'h1,
    HGP_OUT_INV_REG = 3'h2,
    HGP_OUT_DDR = 3'h3,
    HGP_OUT_SER = 3'h4
  } hgp_out_mode_e;

  typedef enum logic [1:0] {
    HGP_CONST_NONE = 2'h0,
    HGP_CONST_ONE = 2'h1,
    HGP_CONST_ZERO = 2'h2
  } hgp_const_e;

  typedef struct packed {
    hgp_dir_e dir;
    hgp_in_mode_e in_mode;
    hgp_align_e align;
    logic rx_clk_inv;
    hgp_out_mode_e out_mode;
    logic tx_clk_inv;
    logic oe_reg;
    hgp_const_e const_out;
    logic differential;
    logic unused_pull_down;
    logic dyn_dly_en;
    logic [5:0] static_dly;
  } hgp_cfg_s;

  typedef struct packed {
    logic delay_step_enable;
    logic delay_step_direction;
    logic delay_counter_clear;
  } hgp_dly_s;

  typedef struct packed {
    hgp_phase_e ph;
    logic [3:0] rx_sh;
    logic cap_r;
    logic cap_f;
    logic [3:0] in_word;
    logic byp;
    logic [1:0][3:0] fifo;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] cnt;
    logic ready;
    logic [3:0] tx_sh;
    logic [3:0] last_w;
    logic pad_o;
    logic oe_p;
    logic oe_n;
    logic pad_n;
    logic pu;
    logic pd;
    logic [5:0] dyn;
    logic [5:0] stat;
  } hgp_state_s;

  // Weak pull-up from reset, buffer ready, delay at its initial tap
  localparam hgp_state_s HGP_ST_RST = '{
    ph: HGP_PH_RISE, ready: 1'b1, pu: 1'b1, pad_n: 1'b1, dyn: DYN_TAP_INIT,
    default: '0};

endpackage

// [core/hgp_io_logic.sv]
// Per-pin I/O logic: registers, dual-edge, serdes, delays and buffer
`timescale 1ns/1ns
module hgp_io_logic (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire hgp_pkg::hgp_cfg_s i_cfg,
  input wire logic i_pad_p,
  input wire logic [3:0] i_out_word,
  input wire logic i_out_valid,
  output logic o_out_ready,
  input wire logic i_oe,
  input wire logic i_complement_drive_enable,
  input wire hgp_pkg::hgp_dly_s i_dly,
  output logic [3:0] o_in_word,
  output logic o_alternate_input_path,
  output logic o_pad_p,
  output logic o_pad_p_oe,
  output logic o_pad_n,
  output logic o_pad_n_oe,
  output logic o_pull_up,
  output logic o_pull_down,
  output logic [5:0] o_dyn_tap,
  output logic [5:0] o_static_tap
);

  hgp_pkg::hgp_state_s st_ff;
  hgp_pkg::hgp_state_s nxt_st;
  logic rx_rise;
  logic rx_fall;
  logic tx_rise;
  logic tx_fall;
  logic push;
  logic pop;
  logic drain;
  logic dly_tick;
  logic oe_p_src;
  logic oe_n_src;
  logic [3:0] ser_w;

  // Slow clock edges as enables; inversion swaps which phase counts as rising
  assign rx_rise = st_ff.ph == (i_cfg.rx_clk_inv ? hgp_pkg::HGP_PH_FALL : hgp_pkg::HGP_PH_RISE);
  assign rx_fall = st_ff.ph == (i_cfg.rx_clk_inv ? hgp_pkg::HGP_PH_RISE : hgp_pkg::HGP_PH_FALL);
  assign tx_rise = st_ff.ph == (i_cfg.tx_clk_inv ? hgp_pkg::HGP_PH_FALL : hgp_pkg::HGP_PH_RISE);
  assign tx_fall = st_ff.ph == (i_cfg.tx_clk_inv ? hgp_pkg::HGP_PH_RISE : hgp_pkg::HGP_PH_FALL);

  always_comb begin
    nxt_st = st_ff;
    // Divider: fast rate is the system clock, slow rate one quarter of it
    unique case (st_ff.ph)
      hgp_pkg::HGP_PH_RISE: nxt_st.ph = hgp_pkg::HGP_PH_Q1;
      hgp_pkg::HGP_PH_Q1: nxt_st.ph = hgp_pkg::HGP_PH_FALL;
      hgp_pkg::HGP_PH_FALL: nxt_st.ph = hgp_pkg::HGP_PH_Q3;
      hgp_pkg::HGP_PH_Q3: nxt_st.ph = hgp_pkg::HGP_PH_RISE;
      default: nxt_st.ph = hgp_pkg::HGP_PH_RISE;
    endcase

    // Input side
    nxt_st.rx_sh = {i_pad_p, st_ff.rx_sh[3:1]};
    nxt_st.byp = i_pad_p;
    if (rx_rise) begin
      nxt_st.cap_r = i_pad_p;
    end
    if (rx_fall) begin
      nxt_st.cap_f = i_pad_p;
    end
    unique case (i_cfg.in_mode)
      hgp_pkg::HGP_IN_DIRECT: nxt_st.in_word = {3'h0, i_pad_p};
      hgp_pkg::HGP_IN_REG: begin
        if (rx_rise) begin
          nxt_st.in_word = {3'h0, i_pad_p};
        end
      end
      hgp_pkg::HGP_IN_DDR: begin
        nxt_st.in_word[3:2] = 2'h0;
        unique case (i_cfg.align)
          hgp_pkg::HGP_AL_NORMAL: begin
            if (rx_rise) begin
              nxt_st.in_word[0] = i_pad_p;
            end
            if (rx_fall) begin
              nxt_st.in_word[1] = i_pad_p;
            end
          end
          hgp_pkg::HGP_AL_RESYNC: begin
            // Falling sample waits half a slow cycle for the rising edge
            if (rx_rise) begin
              nxt_st.in_word[1:0] = {st_ff.cap_f, i_pad_p};
            end
          end
          hgp_pkg::HGP_AL_PIPELINE: begin
            // Both bits from the same slow period, one period later
            if (rx_rise) begin
              nxt_st.in_word[1:0] = {st_ff.cap_f, st_ff.cap_r};
            end
          end
          default: nxt_st.in_word[1:0] = st_ff.in_word[1:0];
        endcase
      end
      hgp_pkg::HGP_IN_DESER: begin
        // Enum makes serdes and dual-edge exclusive by construction
        if (rx_rise) begin
          nxt_st.in_word = nxt_st.rx_sh;
        end
      end
    endcase

    // Two-entry buffer; outside serializer mode it drains every cycle
    push = i_out_valid & st_ff.ready;
    drain = (i_cfg.out_mode == hgp_pkg::HGP_OUT_SER) ? tx_rise : 1'b1;
    pop = (st_ff.cnt != 2'h0) & drain;
    ser_w = pop ? st_ff.fifo[st_ff.rd_ptr] : st_ff.last_w;
    if (push) begin
      nxt_st.fifo[st_ff.wr_ptr] = i_out_word;
      nxt_st.wr_ptr = ~st_ff.wr_ptr;
    end
    if (pop) begin
      nxt_st.rd_ptr = ~st_ff.rd_ptr;
    end
    nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
    nxt_st.ready = nxt_st.cnt != hgp_pkg::BUF_DEPTH;

    // Output side
    unique case (i_cfg.out_mode)
      hgp_pkg::HGP_OUT_DIRECT: nxt_st.pad_o = i_out_word[0];
      hgp_pkg::HGP_OUT_REG: begin
        if (tx_rise) begin
          nxt_st.pad_o = i_out_word[0];
        end
      end
      hgp_pkg::HGP_OUT_INV_REG: begin
        if (tx_rise) begin
          nxt_st.pad_o = ~i_out_word[0];
        end
      end
      hgp_pkg::HGP_OUT_DDR: begin
        if (tx_rise) begin
          nxt_st.pad_o = i_out_word[0];
        end
        if (tx_fall) begin
          nxt_st.pad_o = i_out_word[1];
        end
      end
      hgp_pkg::HGP_OUT_SER: begin
        // Empty buffer repeats the previous word rather than glitching
        if (tx_rise) begin
          nxt_st.last_w = ser_w;
          nxt_st.pad_o = ser_w[0];
          nxt_st.tx_sh = {1'b0, ser_w[3:1]};
        end else begin
          nxt_st.pad_o = st_ff.tx_sh[0];
          nxt_st.tx_sh = {1'b0, st_ff.tx_sh[3:1]};
        end
      end
      default: nxt_st.pad_o = st_ff.pad_o;
    endcase
    if (i_cfg.const_out == hgp_pkg::HGP_CONST_ONE) begin
      nxt_st.pad_o = 1'b1;
    end else if (i_cfg.const_out == hgp_pkg::HGP_CONST_ZERO) begin
      nxt_st.pad_o = 1'b0;
    end
    nxt_st.pad_n = ~nxt_st.pad_o;

    // Output enables, registered on the slow tx edge when asked
    oe_p_src = i_oe;
    oe_n_src = i_complement_drive_enable;
    if (i_cfg.oe_reg) begin
      oe_p_src = tx_rise ? i_oe : st_ff.oe_p;
      oe_n_src = tx_rise ? i_complement_drive_enable : st_ff.oe_n;
    end
    unique case (i_cfg.dir)
      hgp_pkg::HGP_DIR_UNUSED, hgp_pkg::HGP_DIR_INPUT: begin
        nxt_st.oe_p = 1'b0;
        nxt_st.oe_n = 1'b0;
      end
      hgp_pkg::HGP_DIR_OUTPUT: begin
        nxt_st.oe_p = 1'b1;
        nxt_st.oe_n = i_cfg.differential;
      end
      hgp_pkg::HGP_DIR_INOUT: begin
        nxt_st.oe_p = oe_p_src;
        nxt_st.oe_n = oe_n_src & i_cfg.differential;
      end
    endcase

    // Unused pins float with a weak pull
    nxt_st.pu = (i_cfg.dir == hgp_pkg::HGP_DIR_UNUSED) & ~i_cfg.unused_pull_down;
    nxt_st.pd = (i_cfg.dir == hgp_pkg::HGP_DIR_UNUSED) & i_cfg.unused_pull_down;

    // Dynamic delay, input path only; saturates at both ends
    dly_tick = (i_cfg.in_mode == hgp_pkg::HGP_IN_DIRECT) ? 1'b1 : rx_rise;
    if (i_dly.delay_counter_clear) begin
      nxt_st.dyn = hgp_pkg::DYN_TAP_INIT;
    end else if (i_cfg.dyn_dly_en & i_dly.delay_step_enable & dly_tick) begin
      if (i_dly.delay_step_direction & (st_ff.dyn != hgp_pkg::DYN_TAP_MAX)) begin
        nxt_st.dyn = st_ff.dyn + 6'h01;
      end else if (~i_dly.delay_step_direction & (st_ff.dyn != 6'h00)) begin
        nxt_st.dyn = st_ff.dyn - 6'h01;
      end
    end

    // Static delay: clamp for single-ended, off while dynamic runs on a pair
    if (i_cfg.differential) begin
      nxt_st.stat = i_cfg.dyn_dly_en ? 6'h00 : i_cfg.static_dly;
    end else if (i_cfg.static_dly > hgp_pkg::STAT_SE_MAX) begin
      nxt_st.stat = hgp_pkg::STAT_SE_MAX;
    end else begin
      nxt_st.stat = i_cfg.static_dly;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= hgp_pkg::HGP_ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_out_ready = st_ff.ready;
  assign o_in_word = st_ff.in_word;
  assign o_alternate_input_path = st_ff.byp;
  assign o_pad_p = st_ff.pad_o;
  assign o_pad_p_oe = st_ff.oe_p;
  assign o_pad_n = st_ff.pad_n;
  assign o_pad_n_oe = st_ff.oe_n;
  assign o_pull_up = st_ff.pu;
  assign o_pull_down = st_ff.pd;
  assign o_dyn_tap = st_ff.dyn;
  assign o_static_tap = st_ff.stat;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  logic ser_on;
  assign ser_on = (i_cfg.out_mode == hgp_pkg::HGP_OUT_SER) &
    (i_cfg.const_out == hgp_pkg::HGP_CONST_NONE);

  sequence s_ser_load;
    ser_on & tx_rise;
  endsequence

  sequence s_ser_bits;
    (o_pad_p == st_ff.last_w[0]) ##1 (o_pad_p == st_ff.last_w[1]) ##1
      (o_pad_p == st_ff.last_w[2]) ##1 (o_pad_p == st_ff.last_w[3]);
  endsequence

  AST_DDR_RISE: assert property (
    (i_cfg.in_mode == hgp_pkg::HGP_IN_DDR) && (i_cfg.align == hgp_pkg::HGP_AL_NORMAL)
      && rx_rise |=> o_in_word[0] == $past(i_pad_p))
    else $error("rising sample not on bit 0");

  AST_DDR_FALL: assert property (
    (i_cfg.in_mode == hgp_pkg::HGP_IN_DDR) && (i_cfg.align == hgp_pkg::HGP_AL_NORMAL)
      && rx_fall |=> o_in_word[1] == $past(i_pad_p))
    else $error("falling sample not on bit 1");

  // Pad history seen here predates reset until three edges have passed
  AST_DESER_ORDER: assert property (
    (i_cfg.in_mode == hgp_pkg::HGP_IN_DESER) && rx_rise && $past(i_rst_n, 3) |=>
      o_in_word == {$past(i_pad_p, 1), $past(i_pad_p, 2), $past(i_pad_p, 3), $past(i_pad_p, 4)})
    else $error("deserialized word out of order");

  AST_SER_ORDER: assert property (
    s_ser_load |=> s_ser_bits)
    else $error("serial bits out of order");

  AST_DDR_OUT: assert property (
    (i_cfg.out_mode == hgp_pkg::HGP_OUT_DDR) && (i_cfg.const_out == hgp_pkg::HGP_CONST_NONE)
      && tx_fall |=> o_pad_p == $past(i_out_word[1]))
    else $error("falling launch not bit 1");

  AST_DLY_UP: assert property (
    i_cfg.dyn_dly_en && i_dly.delay_step_enable && i_dly.delay_step_direction && dly_tick
      && !i_dly.delay_counter_clear && (o_dyn_tap != hgp_pkg::DYN_TAP_MAX)
      |=> o_dyn_tap == $past(o_dyn_tap) + 6'h01)
    else $error("delay did not step up");

  AST_DLY_DOWN: assert property (
    i_cfg.dyn_dly_en && i_dly.delay_step_enable && !i_dly.delay_step_direction && dly_tick
      && !i_dly.delay_counter_clear && (o_dyn_tap != 6'h00)
      |=> o_dyn_tap == $past(o_dyn_tap) - 6'h01)
    else $error("delay did not step down");

  AST_DLY_CLR: assert property (
    i_dly.delay_counter_clear |=> o_dyn_tap == hgp_pkg::DYN_TAP_INIT)
    else $error("delay clear ignored");

  AST_NO_DUAL_DLY: assert property (
    i_cfg.differential && i_cfg.dyn_dly_en |=> o_static_tap == 6'h00)
    else $error("static and dynamic delay both active");

  AST_CONST_HIGH: assert property (
    (i_cfg.const_out == hgp_pkg::HGP_CONST_ONE) [*2] |-> o_pad_p)
    else $error("constant one not on pad");

  AST_OE_FOLLOW: assert property (
    (i_cfg.dir == hgp_pkg::HGP_DIR_INOUT) && !i_cfg.oe_reg |=> o_pad_p_oe == $past(i_oe))
    else $error("pad enable does not follow core");

  AST_UNUSED_PULL: assert property (
    (i_cfg.dir == hgp_pkg::HGP_DIR_UNUSED) && !i_cfg.unused_pull_down |=>
      o_pull_up && !o_pull_down && !o_pad_p_oe)
    else $error("unused pin not pulled up");

  AST_ALT_BYPASS: assert property (
    1'b1 |=> o_alternate_input_path == $past(i_pad_p))
    else $error("alternate path is not a plain pad copy");

endmodule

// [verif/hgp_pad_model.sv]
// Far-side device model seen at pad P
`timescale 1ns/1ns
module hgp_pad_model (
  input wire logic i_pad_o,
  input wire logic i_pad_oe,
  input wire logic i_pull_up,
  input wire logic i_pull_down,
  input wire logic i_drv,
  output logic o_pad
);
  // Pin driver wins over the pulls, and the pulls win over the far side
  always_comb begin
    if (i_pad_oe) begin
      o_pad = i_pad_o;
    end else if (i_pull_up | i_pull_down) begin
      o_pad = i_pull_up;
    end else begin
      o_pad = i_drv;
    end
  end
endmodule

// [verif/hgp_io_logic_bench.sv]
// Self-checking bench for the pad I/O logic
`timescale 1ns/1ns
module hgp_io_logic_bench;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  hgp_pkg::hgp_cfg_s cfg = '0;
  hgp_pkg::hgp_cfg_s c = '0;
  hgp_pkg::hgp_dly_s dly = '0;
  logic [3:0] word = 4'h0;
  logic drv = 1'b0;
  logic valid = 1'b0;
  logic oe = 1'b0;
  logic pad, rdy, alternate_input_path, pad_o, pad_oe, pad_n, pad_n_oe, pu, pd, took;
  logic [3:0] in_word, e_in;
  logic [5:0] dyn, stat, e_dyn;
  logic [7:0] hist;
  logic e_pad, e_oe;
  int fails = 0;
  int checks_done = 0;
  int k = 0;

  always #5 i_sys_clk = ~i_sys_clk;

  hgp_io_logic DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_cfg(cfg), .i_pad_p(pad),
    .i_out_word(word), .i_out_valid(valid), .o_out_ready(rdy), .i_oe(oe),
    .i_complement_drive_enable(oe), .i_dly(dly), .o_in_word(in_word),
    .o_alternate_input_path(alternate_input_path), .o_pad_p(pad_o), .o_pad_p_oe(pad_oe), .o_pad_n(pad_n),
    .o_pad_n_oe(pad_n_oe), .o_pull_up(pu), .o_pull_down(pd), .o_dyn_tap(dyn),
    .o_static_tap(stat));

  hgp_pad_model far_side (.i_pad_o(pad_o), .i_pad_oe(pad_oe), .i_pull_up(pu),
    .i_pull_down(pd), .i_drv(drv), .o_pad(pad));

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Expectations follow the pre-edge inputs, read before the edge's updates land
  task automatic tick();
    logic tr, tf, rr, rf;
    @(posedge i_sys_clk);
    if (i_rst_n) begin
      tr = (k % 4) == (cfg.tx_clk_inv ? 2 : 0);
      tf = (k % 4) == (cfg.tx_clk_inv ? 0 : 2);
      rr = (k % 4) == (cfg.rx_clk_inv ? 2 : 0);
      rf = (k % 4) == (cfg.rx_clk_inv ? 0 : 2);
      hist = {hist[6:0], pad};
      took = valid & rdy;
      case (cfg.out_mode)
        hgp_pkg::HGP_OUT_DIRECT: e_pad = word[0];
        hgp_pkg::HGP_OUT_REG: if (tr) e_pad = word[0];
        hgp_pkg::HGP_OUT_INV_REG: if (tr) e_pad = ~word[0];
        hgp_pkg::HGP_OUT_DDR: if (tr | tf) e_pad = word[tf];
        default: ;
      endcase
      e_oe = (cfg.dir == hgp_pkg::HGP_DIR_OUTPUT) | ((cfg.dir == hgp_pkg::HGP_DIR_INOUT) &
        ((cfg.oe_reg & !tr) ? e_oe : oe));
      case (cfg.in_mode)
        hgp_pkg::HGP_IN_DIRECT: e_in[0] = pad;
        hgp_pkg::HGP_IN_REG: if (rr) e_in[0] = pad;
        hgp_pkg::HGP_IN_DDR: begin
          if (cfg.align == hgp_pkg::HGP_AL_NORMAL) begin
            if (rr) e_in[0] = pad;
            if (rf) e_in[1] = pad;
          end else if (rr) begin
            e_in[1:0] = {hist[2], (cfg.align == hgp_pkg::HGP_AL_RESYNC) ? hist[0] : hist[4]};
          end
        end
        default: if (rr) e_in = {hist[0], hist[1], hist[2], hist[3]};
      endcase
      if (dly.delay_counter_clear) begin
        e_dyn = hgp_pkg::DYN_TAP_INIT;
      end else if ((cfg.in_mode == hgp_pkg::HGP_IN_DIRECT | rr) & cfg.dyn_dly_en &
          dly.delay_step_enable) begin
        e_dyn = dly.delay_step_direction ? e_dyn + 6'(e_dyn != hgp_pkg::DYN_TAP_MAX) :
          e_dyn - 6'(e_dyn != 6'h00);
      end
      k++;
    end
    #1;
  endtask

  task automatic reset(input hgp_pkg::hgp_cfg_s nc);
    i_rst_n = 1'b0;
    cfg = nc;
    valid = 1'b0;
    dly = '0;
    repeat (5) tick();
    chk("ready_rst", 8'h01, 8'(rdy));
    chk("pull_up_rst", 8'h01, 8'(pu));
    chk("tap_rst", 8'(hgp_pkg::DYN_TAP_INIT), 8'(dyn));
    i_rst_n = 1'b1;
    k = 0;
    hist = '0;
    {e_pad, e_oe, e_in, e_dyn} = '0;
  endtask

  task automatic run(input int n);
    logic [3:0] m;
    logic [5:0] es;
    logic ep;
    m = (c.in_mode == hgp_pkg::HGP_IN_DESER) ? 4'hf :
      (c.in_mode == hgp_pkg::HGP_IN_DDR) ? 4'h3 : 4'h1;
    es = c.differential ? (c.dyn_dly_en ? 6'h00 : c.static_dly) :
      ((c.static_dly > hgp_pkg::STAT_SE_MAX) ? hgp_pkg::STAT_SE_MAX : c.static_dly);
    reset(c);
    for (int i = 0; i < n; i++) begin
      tick();
      ep = (c.const_out == hgp_pkg::HGP_CONST_ONE) |
        ((c.const_out == hgp_pkg::HGP_CONST_NONE) & e_pad);
      if (k > 9) begin
        chk("dyn_tap", 8'(e_dyn), 8'(dyn));
        chk("static_tap", 8'(es), 8'(stat));
        chk("pad_oe", 8'(e_oe), 8'(pad_oe));
        if (c.dir[1]) chk("pad", 8'(ep), 8'(pad_o));
        if (c.differential) chk("pad_n", {6'h00, e_oe, ~ep}, {6'h00, pad_n_oe, pad_n});
        if (c.dir == hgp_pkg::HGP_DIR_INPUT) begin
          chk("in_word", 8'(e_in & m), 8'(in_word & m));
          chk("alt", 8'(hist[0]), 8'(alternate_input_path));
        end
        if (c.dir == hgp_pkg::HGP_DIR_UNUSED) chk("pulls", {6'h00, !c.unused_pull_down,
          c.unused_pull_down}, {6'h00, pu, pd});
      end
      drv = 1'($urandom);
      word = 4'($urandom);
      oe = 1'($urandom);
      valid = 1'($urandom);
      dly.delay_step_enable = ($urandom % 4) != 0;
      dly.delay_step_direction = (i % 256) < 128;
      dly.delay_counter_clear = ($urandom % 97) == 0;
    end
  endtask

  // Words are offered faster than the serializer drains them, so the buffer must refuse
  task automatic ser_test();
    logic [3:0] w[$];
    logic got[$];
    logic full;
    int off;
    c = '0;
    c.dir = hgp_pkg::HGP_DIR_OUTPUT;
    c.out_mode = hgp_pkg::HGP_OUT_SER;
    reset(c);
    full = 1'b0;
    word = 4'h1;
    valid = 1'b1;
    for (int i = 0; i < 400 && w.size() < 12; i++) begin
      tick();
      got.push_back(pad_o);
      full |= !rdy;
      if (took) begin
        w.push_back(word);
        word = 4'($urandom);
      end
    end
    valid = 1'b0;
    repeat (60) begin
      tick();
      got.push_back(pad_o);
    end
    chk("words_taken", 8'd12, 8'(w.size()));
    chk("refused", 8'h01, 8'(full));
    chk("drained_ready", 8'h01, 8'(rdy));
    off = 0;
    while (off < got.size() - 48 && got[off] !== 1'b1) off++;
    // First word is taken on a tx rise and popped on the next, four edges on
    chk("ser_start", 8'd4, 8'(off));
    for (int j = 0; j < 48; j++) chk("ser_bit", 8'(w[j / 4][j % 4]), 8'(got[off + j]));
  endtask

  initial begin
    void'($urandom(32'hc09f));
    c.unused_pull_down = 1'b1;
    c.static_dly = 6'h14;
    run(40);
    c.unused_pull_down = 1'b0;
    run(20);
    c.dir = hgp_pkg::HGP_DIR_INPUT;
    c.dyn_dly_en = 1'b1;
    run(600);
    c.in_mode = hgp_pkg::HGP_IN_REG;
    c.rx_clk_inv = 1'b1;
    c.differential = 1'b1;
    run(300);
    c = '0;
    c.dir = hgp_pkg::HGP_DIR_INPUT;
    c.in_mode = hgp_pkg::HGP_IN_DDR;
    for (int a = 0; a < 3; a++) begin
      c.align = hgp_pkg::hgp_align_e'(a);
      run(200);
    end
    c.in_mode = hgp_pkg::HGP_IN_DESER;
    run(200);
    c = '0;
    c.dir = hgp_pkg::HGP_DIR_OUTPUT;
    for (int m = 0; m < 8; m++) begin
      c.out_mode = hgp_pkg::hgp_out_mode_e'(m % 4);
      c.tx_clk_inv = m[2];
      run(100);
    end
    c.dir = hgp_pkg::HGP_DIR_INOUT;
    c.out_mode = hgp_pkg::HGP_OUT_REG;
    c.differential = 1'b1;
    c.static_dly = 6'h2a;
    for (int m = 0; m < 6; m++) begin
      c.oe_reg = m[0];
      c.const_out = hgp_pkg::hgp_const_e'(m / 2);
      run(60);
    end
    ser_test();
    summarize();
  end
endmodule
